// file: inc/gpwk_defs.vh
`ifndef GPWK_DEFS_VH
`define GPWK_DEFS_VH

// Register offsets within the port block (data-memory byte addresses).
`define GPWK_OFS_A_WAKE 5'h00
`define GPWK_OFS_A_PU 5'h01
`define GPWK_OFS_A_DATA 5'h02
`define GPWK_OFS_A_DIR 5'h03
`define GPWK_OFS_B_PU 5'h04
`define GPWK_OFS_B_DATA 5'h05
`define GPWK_OFS_B_DIR 5'h06
`define GPWK_OFS_C_PU 5'h07
`define GPWK_OFS_C_DATA 5'h08
`define GPWK_OFS_C_DIR 5'h09
`define GPWK_OFS_D_PU 5'h0a
`define GPWK_OFS_D_DATA 5'h0b
`define GPWK_OFS_D_DIR 5'h0c
`define GPWK_OFS_E_PU 5'h0d
`define GPWK_OFS_E_DATA 5'h0e
`define GPWK_OFS_E_DIR 5'h0f
`define GPWK_OFS_F_PU 5'h10
`define GPWK_OFS_F_DATA 5'h11
`define GPWK_OFS_F_DIR 5'h12
`define GPWK_OFS_G_PU 5'h13
`define GPWK_OFS_G_DATA 5'h14
`define GPWK_OFS_G_DIR 5'h15
`define GPWK_OFS_H_PU 5'h16
`define GPWK_OFS_H_DATA 5'h17
`define GPWK_OFS_H_DIR 5'h18

// Reset values.
`define GPWK_RST_WAKE 8'h00
`define GPWK_RST_PU 8'h00
`define GPWK_RST_DATA 8'hff
`define GPWK_RST_DIR 8'hff

// Implemented-pin masks.
`define GPWK_MASK_FULL 8'hff
`define GPWK_MASK_F 8'h7f
`define GPWK_MASK_H 8'h3f

`endif

// file: rtl/gpwk_port.v
`timescale 1ns/1ps
`include "gpwk_defs.vh"

module gpwk_port #(
    parameter [7:0] PIN_MASK = `GPWK_MASK_FULL
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Register writes
    input wire i_wr_pu,
    input wire i_wr_data,
    input wire i_wr_dir,
    input wire [7:0] i_wdata,
    // Pin levels
    input wire [7:0] i_pin,
    // Register contents and read views
    output wire [7:0] o_pu,
    output wire [7:0] o_data,
    output wire [7:0] o_dir,
    output wire [7:0] o_rd_data,
    // Pin drive
    output wire [7:0] o_pin_out,
    output wire [7:0] o_pin_oe,
    output wire [7:0] o_pullup_on
);
    reg [7:0] pu_r;
    reg [7:0] data_r;
    reg [7:0] dir_r;
    genvar g;

    always @(posedge i_clk) begin
        if (i_rst) begin
            pu_r <= `GPWK_RST_PU & PIN_MASK;
            data_r <= `GPWK_RST_DATA & PIN_MASK;
            dir_r <= `GPWK_RST_DIR & PIN_MASK;
        end else begin
            if (i_wr_pu)
                pu_r <= i_wdata & PIN_MASK;
            if (i_wr_data)
                data_r <= i_wdata & PIN_MASK;
            if (i_wr_dir)
                dir_r <= i_wdata & PIN_MASK;
        end
    end

    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pin
            if (PIN_MASK[g]) begin : g_impl
                assign o_pin_oe[g] = ~dir_r[g];
                assign o_pin_out[g] = data_r[g];
                assign o_pullup_on[g] = pu_r[g] & dir_r[g];
                // Input pins read the live level; outputs read back the latch.
                assign o_rd_data[g] = dir_r[g] ? i_pin[g] : data_r[g];
            end else begin : g_none
                assign o_pin_oe[g] = 1'b0;
                assign o_pin_out[g] = 1'b0;
                assign o_pullup_on[g] = 1'b0;
                assign o_rd_data[g] = 1'b0;
            end
        end
    endgenerate

    assign o_pu = pu_r;
    assign o_data = data_r;
    assign o_dir = dir_r;
endmodule // gpwk_port

// file: rtl/gpwk_gpio.v
// Functional notes
// - Output latch holds written data until rewritten.
// - Input pin level sampled directly when port read.
// - Direction bit 0 output, 1 input.
// - Pull-up active only when enabled and input.
// - Enabled Port A falling edge wakes halted device.
// - Port A wake enables, read-write, reset zero.
// - Unimplemented port bits read as zero.
// - Eight ports; F has seven, H six pins.
// - All port registers mapped as data memory.
// - Output pin reads return latch, not pin.
// - Reset makes every pin an input.
`timescale 1ns/1ps
`include "gpwk_defs.vh"

module gpwk_gpio (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Data-memory access
    input wire [4:0] i_addr,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata,
    output reg o_hit,
    // Power-mode controller
    input wire i_halted,
    output reg o_wake_req,
    // Pins, port A in bits 7:0 up to port H in bits 63:56
    input wire [63:0] i_pin,
    output reg [63:0] o_pin_out,
    output reg [63:0] o_pin_oe,
    output reg [63:0] o_pullup_on
);
    reg [7:0] wake_en_r;
    reg [7:0] pa_prev_r;
    reg wake_nxt;
    reg [7:0] rdata_nxt;
    reg hit_nxt;
    wire [63:0] pu_w;
    wire [63:0] data_w;
    wire [63:0] dir_w;
    wire [63:0] rd_w;
    wire [63:0] pout_w;
    wire [63:0] poe_w;
    wire [63:0] ppu_w;
    wire [4:0] base_w [0:7];
    genvar p;

    assign base_w[0] = `GPWK_OFS_A_PU;
    assign base_w[1] = `GPWK_OFS_B_PU;
    assign base_w[2] = `GPWK_OFS_C_PU;
    assign base_w[3] = `GPWK_OFS_D_PU;
    assign base_w[4] = `GPWK_OFS_E_PU;
    assign base_w[5] = `GPWK_OFS_F_PU;
    assign base_w[6] = `GPWK_OFS_G_PU;
    assign base_w[7] = `GPWK_OFS_H_PU;

    // Each port holds pull-up, data and direction at base, base+1, base+2.
    generate
        for (p = 0; p < 8; p = p + 1) begin : g_port
            gpwk_port #(
                .PIN_MASK((p == 5) ? `GPWK_MASK_F : ((p == 7) ? `GPWK_MASK_H : `GPWK_MASK_FULL))
            ) u_port (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_wr_pu(i_wr && (i_addr == base_w[p])),
                .i_wr_data(i_wr && (i_addr == base_w[p] + 5'h01)),
                .i_wr_dir(i_wr && (i_addr == base_w[p] + 5'h02)),
                .i_wdata(i_wdata),
                .i_pin(i_pin[p*8 +: 8]),
                .o_pu(pu_w[p*8 +: 8]),
                .o_data(data_w[p*8 +: 8]),
                .o_dir(dir_w[p*8 +: 8]),
                .o_rd_data(rd_w[p*8 +: 8]),
                .o_pin_out(pout_w[p*8 +: 8]),
                .o_pin_oe(poe_w[p*8 +: 8]),
                .o_pullup_on(ppu_w[p*8 +: 8])
            );
        end
    endgenerate

    // Read mux; data reads take the pin level at the edge that ends the read.
    always @* begin : rd_mux
        integer k;
        rdata_nxt = 8'h00;
        hit_nxt = 1'b0;
        if (i_addr == `GPWK_OFS_A_WAKE) begin
            rdata_nxt = wake_en_r;
            hit_nxt = 1'b1;
        end
        for (k = 0; k < 8; k = k + 1) begin
            if (i_addr == base_w[k]) begin
                rdata_nxt = pu_w[k*8 +: 8];
                hit_nxt = 1'b1;
            end
            if (i_addr == base_w[k] + 5'h01) begin
                rdata_nxt = rd_w[k*8 +: 8];
                hit_nxt = 1'b1;
            end
            if (i_addr == base_w[k] + 5'h02) begin
                rdata_nxt = dir_w[k*8 +: 8];
                hit_nxt = 1'b1;
            end
        end
    end

    always @* begin
        wake_nxt = i_halted && |(wake_en_r & pa_prev_r & ~i_pin[7:0]);
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            wake_en_r <= `GPWK_RST_WAKE;
            pa_prev_r <= 8'hff;
            o_wake_req <= 1'b0;
            o_rdata <= 8'h00;
            o_hit <= 1'b0;
            o_pin_out <= 64'h0000000000000000;
            o_pin_oe <= 64'h0000000000000000;
            o_pullup_on <= 64'h0000000000000000;
        end else begin
            if (i_wr && (i_addr == `GPWK_OFS_A_WAKE))
                wake_en_r <= i_wdata;
            pa_prev_r <= i_pin[7:0];
            o_wake_req <= wake_nxt;
            if (i_rd) begin
                o_rdata <= rdata_nxt;
                o_hit <= hit_nxt;
            end
            o_pin_out <= pout_w;
            o_pin_oe <= poe_w;
            o_pullup_on <= ppu_w;
        end
    end
endmodule // gpwk_gpio

// file: verif/gpwk_switches.sv
`timescale 1ns/1ps
module gpwk_switches (
    input wire [63:0] i_out,
    input wire [63:0] i_oe,
    input wire [63:0] i_sw,
    output wire [63:0] o_pin
);
    // Driven pins show the latch; on input pins the outside circuit sets the level.
    assign o_pin = i_oe & i_out | ~i_oe & i_sw;
endmodule // gpwk_switches

// file: verif/gpwk_gpio_properties.sv
`timescale 1ns/1ps
module gpwk_chk (
    input wire i_clk,
    input wire i_rst,
    input wire [4:0] i_addr,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    input wire o_hit,
    input wire i_halted,
    input wire o_wake_req,
    input wire [63:0] i_pin,
    input wire [63:0] o_pin_out,
    input wire [63:0] o_pin_oe,
    input wire [63:0] o_pullup_on
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_quiet; !i_wr ##1 !i_wr; endsequence
    a_latch_hold: assert property (s_quiet |=> $stable(o_pin_out) && $stable(o_pin_oe)) else $error("pin moved");
    a_pullup_input: assert property ((o_pullup_on & o_pin_oe) == 64'h0) else $error("pullup on output");
    a_unimpl_pins: assert property (((o_pin_oe | o_pin_out | o_pullup_on) & 64'hc000_8000_0000_0000) == 64'h0)
        else $error("absent pin used");
    a_reset_input: assert property ($past(i_rst) |-> o_pin_oe == 64'h0) else $error("pin driven");
    a_rd_hold: assert property (!$past(i_rd) |-> $stable(o_rdata)) else $error("rdata moved");
    a_unmapped_rd: assert property ($past(i_rd) && $past(i_addr) > 5'h18 |-> o_rdata == 8'h00 && !o_hit)
        else $error("unmapped read");
    a_unimpl_bits: assert property ($past(i_rd) && $past(i_addr) inside {[5'h10:5'h12], [5'h16:5'h18]} |-> !o_rdata[7])
        else $error("absent bit set");
    a_wake_cause: assert property (o_wake_req |-> $past(i_halted) && |($past(i_pin[7:0], 2) & ~$past(i_pin[7:0])))
        else $error("wake without fall");
endmodule // gpwk_chk
bind gpwk_gpio gpwk_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_hit(o_hit), .i_halted(i_halted), .o_wake_req(o_wake_req), .i_pin(i_pin),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pullup_on(o_pullup_on));

// file: verif/gpwk_gpio_tb.sv
`timescale 1ns/1ps
module gpwk_gpio_tb;
    reg i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_halted = 0, rq = 0;
    reg [4:0] i_addr = 0;
    reg [7:0] i_wdata = 0, lf = 8'h20, m[0:24];
    reg [8:0] q[$];
    reg [8:0] qe;
    reg [63:0] sw = 0;
    wire [7:0] o_rdata;
    wire o_wake_req, o_hit;
    wire [63:0] pin, po, oe, pu;
    integer n_mismatch = 0, n_tests = 0, cyc = 0, i, j;
    gpwk_gpio dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata),
        .o_rdata(o_rdata), .o_hit(o_hit), .i_halted(i_halted), .o_wake_req(o_wake_req), .i_pin(pin),
        .o_pin_out(po), .o_pin_oe(oe), .o_pullup_on(pu));
    gpwk_switches sws (.i_out(po), .i_oe(oe), .i_sw(sw), .o_pin(pin));
    initial forever #4 i_clk = ~i_clk;
    function [7:0] nx(input [7:0] v);
        nx = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function [7:0] mk(input integer a);
        mk = a > 21 ? 8'h3f : a > 15 && a < 19 ? 8'h7f : 8'hff;
    endfunction
    // Data reads mix the latch on output pins with the live level on input pins.
    function [7:0] ex(input integer a);
        ex = a > 24 ? 8'h00 : a % 3 != 2 ? m[a] : (m[a] & ~m[a + 1] | sw[a / 3 * 8 +: 8] & m[a + 1]) & mk(a);
    endfunction
    task check(input string nm, input [7:0] s, input [7:0] e);
        n_tests = n_tests + 1;
        if (s !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask
    task wr(input integer a, input [7:0] d);
        i_addr = a[4:0];
        i_wdata = d;
        i_wr = 1;
        m[a] = d & mk(a);
        @(posedge i_clk) #1;
    endtask
    task rall;
        for (i = 0; i < 32; i++) begin
            i_addr = i[4:0];
            i_rd = 1;
            q.push_back({i < 25, ex(i)});
            @(posedge i_clk) #1;
        end
        i_rd = 0;
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge i_clk) begin
        if (rq) begin
            qe = q.pop_front();
            check("rdata", o_rdata, qe[7:0]);
            check("hit", {7'h00, o_hit}, {7'h00, qe[8]});
        end
        rq = i_rd;
        cyc = cyc + 1;
        if (cyc == 1000) begin
            n_mismatch = n_mismatch + 1;
            stop_test;
        end
    end
    initial begin
        for (i = 0; i < 25; i++) m[i] = i % 3 == 1 || i == 0 ? 8'h00 : mk(i);
        repeat (10) @(posedge i_clk);
        #1 i_rst = 0;
        rall;
        $display("reset values done");
        repeat (2) begin
            for (j = 0; j < 25; j++) begin
                lf = nx(lf);
                sw = {sw[55:0], lf};
                wr(j, lf);
            end
            i_wr = 0;
            repeat (3) @(posedge i_clk);
            #1;
            for (j = 0; j < 8; j++) begin
                check("pin_out", po[j*8 +: 8], m[3*j+2]);
                check("pin_oe", oe[j*8 +: 8], ~m[3*j+3] & mk(3*j+2));
                check("pullup", pu[j*8 +: 8], m[3*j+1] & m[3*j+3]);
            end
            rall;
        end
        $display("random access done");
        wr(3, 8'hff);
        wr(0, 8'h01);
        i_wr = 0;
        sw = 64'hff;
        i_halted = 1;
        repeat (3) @(posedge i_clk);
        #1 sw[1] = 0;
        repeat (3) begin
            @(posedge i_clk);
            #1 check("wake", o_wake_req, 0);
        end
        sw[0] = 0;
        for (i = 0; i < 3 && o_wake_req !== 1'b1; i++) @(posedge i_clk) #1;
        check("wake", o_wake_req, 1);
        @(posedge i_clk) #1 check("wake", o_wake_req, 0);
        $display("wake done");
        stop_test;
    end
endmodule // gpwk_gpio_tb
